/* sim/link_receiver_model.sv */
/*
  Far-end receiver model: powers its front end while link clock current flows.
  Assumes the line code of the link clock arrives as the transmitter drives it.
*/
`timescale 1ns/10ps
module link_receiver_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] serial_link_clock,
  output      logic       rx_on
);
  // ==========================================================================
  // Current sense on the link clock line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rx_on <= 1'b0;
    else rx_on <= (serial_link_clock != 2'h0);
  end
endmodule : link_receiver_model

/* sim/link_startup_chk.sv */
/*
  Checker: start-up pulse lengths, phases, power-down.
  Assumes binding to the top module; sees only its ports.
*/
`timescale 1ns/10ps
module link_startup_chk (
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            pixel_clk,
  input wire logic            power_down_n,
  input wire logic [1:0]      serial_link_clock,
  input wire logic [2:0][1:0] serial_data_lane,
  input wire logic            pll_enable,
  input wire logic [2:0]      link_phase,
  input wire logic            low_power
);
  logic [1:0]      prev_q;
  logic [9:0]      run_q;
  logic [1:0]      mc;
  logic [2:0][1:0] md;
  assign mc = serial_link_clock;
  assign md = serial_data_lane;
  // ====================
  // Run length of the link clock code
  always_ff @(posedge pixel_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 2'h0;
      run_q  <= 10'h000;
    end else begin
      prev_q <= mc;
      run_q  <= (mc == prev_q) ? run_q + 10'h001 : 10'h001;
    end
  end
  // ====================
  // Properties
  property p_low1;
    @(posedge pixel_clk) disable iff (!rst_n)
      prev_q == 2'h2 && mc == 2'h1 |-> run_q == link_startup_pkg::LOW1_CYC;
  endproperty
  a_low1: assert property (p_low1) else $error("low1 length wrong");
  property p_high;
    @(posedge pixel_clk) disable iff (!rst_n)
      prev_q == 2'h1 && mc == 2'h2 |-> run_q == link_startup_pkg::HIGH_CYC;
  endproperty
  a_high: assert property (p_high) else $error("high length wrong");
  property p_lock;
    @(posedge pixel_clk) disable iff (!rst_n) prev_q == 2'h2 && mc == 2'h3
      |-> run_q == link_startup_pkg::LOW2_CYC + link_startup_pkg::LOCK_CYC
      && $past(md) == 6'h2A;
  endproperty
  a_lock: assert property (p_lock) else $error("last low wrong");
  property p_quiet;
    @(posedge pixel_clk) disable iff (!rst_n)
      mc == 2'h1 || (prev_q == 2'h0 && mc == 2'h2) |-> md == 6'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("lane driven in pulse");
  property p_off;
    @(posedge clk) disable iff (!rst_n) link_phase == link_startup_pkg::PHASE_OFF
      |-> mc == 2'h0 && md == 6'h00;
  endproperty
  a_off: assert property (p_off) else $error("current while off");
  property p_order;
    @(posedge pixel_clk) disable iff (!rst_n)
      (link_phase == link_startup_pkg::PHASE_ACTIVE |-> $past(link_phase) != 3'h1) and
      (link_phase == link_startup_pkg::PHASE_LINK_UP |-> $past(link_phase) != 3'h4);
  endproperty
  a_order: assert property (p_order) else $error("illegal phase step");
  property p_pll;
    @(posedge clk) disable iff (!rst_n) mc == 2'h3 |-> pll_enable;
  endproperty
  a_pll: assert property (p_pll) else $error("stream without lock");
  property p_pd;
    @(posedge clk) disable iff (!rst_n) $fell(power_down_n)
      |-> ##[1:12] (low_power && link_phase == 3'h1 && mc == 2'h0);
  endproperty
  a_pd: assert property (p_pd) else $error("power-down ignored");
  c_active: cover property (@(posedge pixel_clk) prev_q == 2'h2 && mc == 2'h3);
  c_high: cover property (@(posedge pixel_clk) prev_q == 2'h1 && mc == 2'h2);
  c_pd: cover property (@(posedge clk) $fell(power_down_n));
endmodule : link_startup_chk

bind pixel_serial_link_startup link_startup_chk u_chk (.clk(clk), .rst_n(rst_n),
  .pixel_clk(pixel_clk), .power_down_n(power_down_n), .serial_link_clock(serial_link_clock),
  .serial_data_lane(serial_data_lane), .pll_enable(pll_enable), .link_phase(link_phase),
  .low_power(low_power));

/* sim/tb_pixel_serial_link_startup.sv */
/*
  Bench: start-up, pixel packing, control writes, power-down, clock stop.
  Assumes package, design and receiver model compiled first.
*/
`timescale 1ns/10ps
module tb_pixel_serial_link_startup;
  logic             clk, rst_n, pixel_clk, pclk_run, power_down_n, rx_on, pll_enable;
  logic             frame_sync, line_sync, pixel_valid, low_power;
  logic             control_select_n, control_clk, control_data;
  logic [23:0]      rgb_in;
  logic [1:0]       serial_link_clock;
  logic [2:0][1:0]  serial_data_lane;
  logic [2:0][11:0] lane_word;
  logic [3:0]       lane_bits;
  logic [2:0]       link_phase;
  logic [26:0]      q[$];
  int               fails, checks, seed;
  // ====================
  // Clocks and instances
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    pixel_clk = 1'b0;
    #1.3;
    forever begin
      #40;
      if (pclk_run) pixel_clk = ~pixel_clk;
    end
  end
  pixel_serial_link_startup u_dut (
    .clk(clk), .rst_n(rst_n), .pixel_clk(pixel_clk), .power_down_n(power_down_n),
    .rgb_in(rgb_in), .frame_sync(frame_sync), .line_sync(line_sync),
    .pixel_valid(pixel_valid), .control_select_n(control_select_n),
    .control_clk(control_clk), .control_data(control_data),
    .serial_link_clock(serial_link_clock), .serial_data_lane(serial_data_lane),
    .lane_word(lane_word), .lane_bits(lane_bits), .pll_enable(pll_enable),
    .link_phase(link_phase), .low_power(low_power));
  link_receiver_model u_rx (.clk(clk), .rst_n(rst_n),
    .serial_link_clock(serial_link_clock), .rx_on(rx_on));
  // ====================
  // Tasks
  task print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task startup;
    int n_off, n_low, n_hi, k;
    n_off = 0;
    n_low = 0;
    n_hi = 0;
    for (k = 0; k < 1400 && link_phase !== 3'h4; k++) begin
      @(negedge pixel_clk);
      if (link_phase === 3'h2) begin
        n_off += (serial_link_clock === 2'h0);
        n_hi  += (serial_link_clock === 2'h1);
        n_low += (serial_link_clock === 2'h2);
      end
    end
    if (k == 1400) begin
      fails++;
      print_verdict();
    end
    chk(n_off, link_startup_pkg::BIAS_CYC);
    chk(n_hi, link_startup_pkg::HIGH_CYC);
    chk(n_low, link_startup_pkg::LOW1_CYC + link_startup_pkg::LOW2_CYC
      + link_startup_pkg::LOCK_CYC);
    chk(rx_on, 1'b1);
    $display("start-up done");
  endtask : startup
  task ctrl_wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {1'b0, a, d};
    @(posedge clk);
    control_select_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      control_data <= f[i];
      control_clk  <= 1'b0;
      repeat (4) @(posedge clk);
      control_clk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    control_select_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : ctrl_wr
  task pix_run(input logic [7:0] cfg, input int n);
    logic [23:0] p, pl;
    logic [26:0] e;
    logic [7:0]  v;
    logic [5:0]  g;
    logic [3:0]  lb;
    logic [1:0]  f, fn;
    q.delete();
    f = 2'h0;
    lb = cfg[1] ? link_startup_pkg::BITS_2LANE : link_startup_pkg::BITS_3LANE;
    ctrl_wr(link_startup_pkg::CFG_ADDR, cfg);
    repeat (3) @(negedge pixel_clk);
    chk(lane_bits, lb);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      p = cfg[0] ? 24'h5A5A5A : $random(seed);
      e = {3'($random(seed)), p};
      rgb_in <= p;
      {pixel_valid, line_sync, frame_sync} <= e[26:24];
      q.push_back(e);
      @(negedge pixel_clk);
      if (k >= 2) begin
        e = q.pop_front();
        pl = {lane_word[2][11:4], lane_word[1][11:4], lane_word[0][11:4]};
        if (cfg[1]) pl = {lane_word[1], lane_word[0]};
        fn = f + 2'h1;
        if (k >= 3) chk(pl[22:21], fn);
        f = pl[22:21];
        chk(pl[20:18], e[26:24]);
        chk(^pl, 1'b1);
        if (cfg[1]) chk(lane_word[2], 12'h000);
        for (int c = 0; c < 3; c++) begin
          v = cfg[0] ? 8'hC3 + 8'(c) : e[8*c +: 8];
          g = pl[6*c +: 6];
          if (cfg[2]) chk(g, v[7:2]);
          else chk(g == v[7:2] || (v[7:2] != 6'h3F && g == v[7:2] + 6'h01), 1'b1);
        end
      end
    end
    $display("pixel run %h done", cfg);
  endtask : pix_run
  task pstop(input int n);
    @(negedge pixel_clk);
    @(posedge clk);
    pclk_run = 1'b0;
    repeat (n * 20) @(posedge clk);
  endtask : pstop
  // ====================
  // Main sequence
  initial begin
    seed = 94214;
    fails = 0;
    checks = 0;
    pclk_run = 1'b1;
    rst_n = 1'b0;
    power_down_n = 1'b1;
    rgb_in = 24'h000000;
    {frame_sync, line_sync, pixel_valid} = 3'h0;
    control_select_n = 1'b1;
    control_clk = 1'b0;
    control_data = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    startup();
    chk(lane_bits, link_startup_pkg::BITS_3LANE);
    pix_run(8'h04, 24);
    pix_run(8'h06, 24);
    pix_run(8'h00, 24);
    for (int t = 0; t < 3; t++) begin
      ctrl_wr(link_startup_pkg::TBL_SEL_ADDR, 8'(t));
      ctrl_wr(link_startup_pkg::TBL_IDX_ADDR, 8'h5A);
      ctrl_wr(link_startup_pkg::TBL_DATA_ADDR, 8'hC3 + 8'(t));
    end
    pix_run(8'h05, 6);
    @(posedge clk);
    power_down_n <= 1'b0;
    repeat (20) @(posedge clk);
    chk({low_power, link_phase, serial_link_clock, serial_data_lane},
      {1'b1, link_startup_pkg::PHASE_OFF, 8'h00});
    power_down_n <= 1'b1;
    startup();
    chk(lane_bits, link_startup_pkg::BITS_3LANE);
    pstop(2);
    pclk_run = 1'b1;
    repeat (200) @(posedge clk);
    chk(link_phase, link_startup_pkg::PHASE_ACTIVE);
    pstop(20);
    chk({low_power, link_phase, serial_link_clock},
      {1'b1, link_startup_pkg::PHASE_OFF, 2'h0});
    $display("clock stop done");
    pclk_run = 1'b1;
    startup();
    print_verdict();
  end
endmodule : tb_pixel_serial_link_startup

/* src/color_table.sv */
/*
  Three colour correction tables, written from the control clock domain
  and read from the pixel clock domain. Assumes writes are rare and
  quasi-static relative to reads.
*/
`timescale 1ns/10ps
module color_table #(
  parameter int unsigned TABLES = 3,
  parameter int unsigned DEPTH  = 256,
  parameter int unsigned WIDTH  = 8
) (
  input  wire logic                            wclk,
  input  wire logic                            we,
  input  wire logic [1:0]                      wsel,
  input  wire logic [$clog2(DEPTH)-1:0]        waddr,
  input  wire logic [WIDTH-1:0]                wdata,
  input  wire logic                            rclk,
  input  wire logic [TABLES-1:0][$clog2(DEPTH)-1:0] raddr,
  output      logic [TABLES-1:0][WIDTH-1:0]    rdata
);
  if (TABLES > 4) begin : g_check
    $error("color_table supports at most four tables");
  end

  // ==========================================================================
  // Storage and ports
  for (genvar t = 0; t < TABLES; t++) begin : g_tbl
    logic [WIDTH-1:0] mem [DEPTH];
    always_ff @(posedge wclk) begin
      if (we && (wsel == 2'(t))) mem[waddr] <= wdata; // RULE3
    end
    always_ff @(posedge rclk) begin
      rdata[t] <= mem[raddr[t]];
    end
  end

endmodule : color_table

/* src/link_startup_pkg.sv */
/*
  Shared constants and types for the serial display link transmitter.
  Assumes every design file refers to these by package-qualified name.
*/
package link_startup_pkg;

  // ==========================================================================
  // Start-up timing, in pixel-clock cycles
  localparam int unsigned BIAS_CYC       = 200;
  localparam int unsigned LOW1_CYC       = 200;
  localparam int unsigned HIGH_CYC       = 20;
  localparam int unsigned LOW2_CYC       = 8;
  localparam int unsigned LOCK_CYC       = 600;
  localparam int unsigned STOP_GAP_PCLK  = 4;
  localparam int unsigned COUNT_W        = 10;

  // ==========================================================================
  // Serial payload layout
  localparam int unsigned PAYLOAD_W      = 24;
  localparam int unsigned LANES          = 3;
  localparam int unsigned WORD_W         = 12;
  localparam logic [3:0]  BITS_3LANE     = 4'h8;
  localparam logic [3:0]  BITS_2LANE     = 4'hC;

  // ==========================================================================
  // Control interface frame and register map
  localparam int unsigned CTRL_FRAME_W   = 16;
  localparam logic [6:0]  CFG_ADDR       = 7'h00;
  localparam logic [6:0]  TBL_SEL_ADDR   = 7'h01;
  localparam logic [6:0]  TBL_IDX_ADDR   = 7'h02;
  localparam logic [6:0]  TBL_DATA_ADDR  = 7'h03;
  localparam int unsigned CFG_TABLE_EN   = 0;
  localparam int unsigned CFG_TWO_LANE   = 1;
  localparam int unsigned CFG_DITHER_OFF = 2;
  localparam logic [7:0]  CFG_RESET      = 8'h00;

  // ==========================================================================
  // Line current codes, sequencer states and link phases
  typedef enum logic [1:0] {
    LINE_OFF    = 2'h0,
    LINE_HIGH   = 2'h1,
    LINE_LOW    = 2'h2,
    LINE_ACTIVE = 2'h3
  } line_t;

  typedef enum logic [6:0] {
    SEQ_OFF    = 7'h01,
    SEQ_BIAS   = 7'h02,
    SEQ_LOW1   = 7'h04,
    SEQ_HIGH   = 7'h08,
    SEQ_LOW2   = 7'h10,
    SEQ_LOCK   = 7'h20,
    SEQ_ACTIVE = 7'h40
  } seq_t;

  typedef enum logic [2:0] {
    PHASE_OFF     = 3'h1,
    PHASE_LINK_UP = 3'h2,
    PHASE_ACTIVE  = 3'h4
  } phase_t;

endpackage : link_startup_pkg

/* src/pixel_bus_if.sv */
/*
  Pixel carrier between the stream logic and the dither stage.
  Assumes both ends run on the pixel clock.
*/
`timescale 1ns/10ps
interface pixel_bus_if;
  logic [23:0] rgb24;
  logic [17:0] rgb18;
  logic        frame_start;
  logic        bypass;

  modport source (output rgb24, output frame_start, output bypass, input rgb18);
  modport dither (input rgb24, input frame_start, input bypass, output rgb18);
endinterface : pixel_bus_if

/* src/pixel_dither.sv */
/*
  Reduces 8-bit colour channels to 6 bits with pseudo-random noise.
  Assumes a pixel-clock domain clock and reset; noise restarts each frame.
*/
`timescale 1ns/10ps
module pixel_dither (
  input  wire logic  clk,
  input  wire logic  rst_n,
  pixel_bus_if.dither bus
);
  // ==========================================================================
  // Noise source
  logic [15:0] lfsr_q;
  logic [15:0] lfsr_d;

  assign lfsr_d = bus.frame_start ? 16'hACE1 :
                  {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lfsr_q <= 16'hACE1;
    else        lfsr_q <= lfsr_d;
  end

  // ==========================================================================
  // Per-channel add, saturate, truncate
  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic [7:0] chan;
    logic [8:0] sum;
    logic [7:0] sat;
    assign chan = bus.rgb24[8*c +: 8];
    assign sum  = {1'b0, chan} + {7'h00, lfsr_q[2*c +: 2]};
    assign sat  = sum[8] ? 8'hFF : sum[7:0];
    assign bus.rgb18[6*c +: 6] = bus.bypass ? chan[7:2] : sat[7:2]; // RULE2
  end

endmodule : pixel_dither

/* src/pixel_serial_link_startup.sv */
/*
  Link start-up sequencer and pixel packer for a current-mode serial link.
  Assumes pixel inputs on pixel_clk,
  an analog stage turning line codes into currents and shifting lane words,
  and clk much faster than pixel_clk.
*/
// Summary of operation
// RULE1 - Sample 24-bit pixels with syncs, pack onto two or three lanes with clock.
// RULE2 - Dither every pixel from 24 to 18 bits before packing; with the dither-off config bit set, pixels are truncated without noise instead.
// RULE3 - Three 256x8 colour tables, loaded over the three-wire control port.
// RULE4 - Link phase follows line states: off, link-up or active only.
// RULE5 - In off, clock and data lines carry no current.
// RULE6 - Line codes: low is high current, high is low current, off is none.
// RULE7 - Start-up begins on power-down release or pixel clock start while enabled.
// RULE8 - After bias-up, hold link clock low for 200 pixel cycles.
// RULE9 - Then drive link clock high for 20 pixel cycles.
// RULE10 - Then drive link clock low again for 8 pixel cycles.
// RULE11 - Then lock the PLL, wait 600 pixel cycles, then stream.
// RULE12 - The far receiver powers up when it senses link clock current.
// RULE13 - A pixel clock stopped four cycles or longer resets the link.
// RULE14 - After a stop, repeat PLL lock and full start-up before streaming.
// RULE15 - In three-lane mode a bit period is one eighth of a pixel period.
// RULE16 - The host touches each colour table once after power-up.
// RULE17 - Active only from link-up, link-up only from off, off from either.
// RULE18 - Data lanes stay off in link-up pulses, low only in the last low.
// RULE19 - Power-down low or stopped pixel clock forces off and low power.
// RULE20 - Three lanes by default; two lanes selectable over the control port.
`timescale 1ns/10ps
module pixel_serial_link_startup #(
  parameter int unsigned MAX_PIXEL_PERIOD_NS = 200,
  parameter int unsigned CLK_PERIOD_NS       = 4
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   pixel_clk,
  input  wire logic                   power_down_n,
  input  wire logic [23:0]            rgb_in,
  input  wire logic                   frame_sync,
  input  wire logic                   line_sync,
  input  wire logic                   pixel_valid,
  input  wire logic                   control_select_n,
  input  wire logic                   control_clk,
  input  wire logic                   control_data,
  output      logic [1:0]             serial_link_clock,
  output      logic [2:0][1:0]        serial_data_lane,
  output      logic [2:0][11:0]       lane_word,
  output      logic [3:0]             lane_bits,
  output      logic                   pll_enable,
  output      logic [2:0]             link_phase,
  output      logic                   low_power
);
  localparam int unsigned STOP_GAP_CYC =
    (link_startup_pkg::STOP_GAP_PCLK * MAX_PIXEL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_W = $clog2(STOP_GAP_CYC + 1);

  if (STOP_GAP_CYC < 8 || STOP_GAP_CYC > 4096) begin : g_check
    $error("pixel clock stop gap out of range");
  end

  // ====================
  // Pixel clock activity, crossed into clk
  logic             pclk_tog_q;
  logic [2:0]       tog_sync_q;
  logic [GAP_W-1:0] gap_q;
  logic [GAP_W-1:0] gap_d;
  logic             stopped_q;
  logic             tog_edge;

  always_ff @(posedge pixel_clk or negedge rst_n) begin
    if (!rst_n) pclk_tog_q <= 1'b0;
    else        pclk_tog_q <= ~pclk_tog_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tog_sync_q <= 3'h0;
    else        tog_sync_q <= {tog_sync_q[1:0], pclk_tog_q};
  end

  assign tog_edge = tog_sync_q[2] ^ tog_sync_q[1];
  assign gap_d    = tog_edge ? '0 : (stopped_q ? gap_q : gap_q + 1'b1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) gap_q <= '0;
    else        gap_q <= gap_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)        stopped_q <= 1'b1;
    else if (tog_edge) stopped_q <= 1'b0;
    else if (gap_q == GAP_W'(STOP_GAP_CYC - 1)) stopped_q <= 1'b1; // RULE13
  end

  // ====================
  // Power-down pin and link run level
  logic [1:0] pd_sync_q;
  logic       run_q;
  logic       pd_high;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pd_sync_q <= 2'h0;
    else        pd_sync_q <= {pd_sync_q[0], power_down_n};
  end

  assign pd_high = pd_sync_q[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) run_q <= 1'b0;
    else        run_q <= pd_high & ~stopped_q; // RULE7
  end

  assign low_power = ~run_q; // RULE19

  // ====================
  // Pixel domain reset: asserts at once, releases on pixel_clk
  logic       link_arst_n;
  logic [1:0] prst_q;
  logic       prst_n;

  assign link_arst_n = rst_n & run_q; // RULE19

  always_ff @(posedge pixel_clk or negedge link_arst_n) begin
    if (!link_arst_n) prst_q <= 2'h0;
    else              prst_q <= {prst_q[0], 1'b1};
  end

  assign prst_n = prst_q[1]; // RULE14

  // ====================
  // Three-wire control receiver
  logic [2:0]  csel_q;
  logic [2:0]  cclk_q;
  logic [1:0]  cdat_q;
  logic [15:0] shift_q;
  logic [4:0]  nbit_q;
  logic        ctrl_rise;
  logic        ctrl_sel;
  logic        frame_done;
  logic [6:0]  frame_addr;
  logic [7:0]  frame_data;
  logic [7:0]  cfg_q;
  logic [1:0]  tsel_q;
  logic [7:0]  tidx_q;
  logic        twe;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csel_q <= 3'h7;
      cclk_q <= 3'h0;
      cdat_q <= 2'h0;
    end else begin
      csel_q <= {csel_q[1:0], control_select_n};
      cclk_q <= {cclk_q[1:0], control_clk};
      cdat_q <= {cdat_q[0], control_data};
    end
  end

  assign ctrl_sel   = ~csel_q[1] & run_q;
  assign ctrl_rise  = ctrl_sel & cclk_q[1] & ~cclk_q[2];
  assign frame_done = ctrl_rise && (nbit_q == 5'(link_startup_pkg::CTRL_FRAME_W - 1));
  assign frame_addr = shift_q[13:7];
  assign frame_data = {shift_q[6:0], cdat_q[1]};
  assign twe        = frame_done & ~shift_q[14]
                      & (frame_addr == link_startup_pkg::TBL_DATA_ADDR);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)         nbit_q <= 5'h00;
    else if (!ctrl_sel) nbit_q <= 5'h00;
    else if (ctrl_rise) nbit_q <= nbit_q + 5'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)         shift_q <= 16'h0000;
    else if (ctrl_rise) shift_q <= {shift_q[14:0], cdat_q[1]};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)       cfg_q <= link_startup_pkg::CFG_RESET;
    else if (!run_q)  cfg_q <= link_startup_pkg::CFG_RESET; // RULE20
    else if (frame_done && !shift_q[14] && frame_addr == link_startup_pkg::CFG_ADDR)
      cfg_q <= frame_data; // RULE20
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tsel_q <= 2'h0;
      tidx_q <= 8'h00;
    end else if (frame_done && !shift_q[14]) begin
      if (frame_addr == link_startup_pkg::TBL_SEL_ADDR) tsel_q <= frame_data[1:0];
      if (frame_addr == link_startup_pkg::TBL_IDX_ADDR) tidx_q <= frame_data;
      if (twe) tidx_q <= tidx_q + 8'h01;
    end
  end

  // ====================
  // Configuration crossed into pixel domain (quasi-static)
  logic [2:0] cfg_s1_q;
  logic [2:0] cfg_s2_q;
  logic       tbl_en;
  logic       two_lane;

  always_ff @(posedge pixel_clk or negedge prst_n) begin
    if (!prst_n) begin
      cfg_s1_q <= 3'h0;
      cfg_s2_q <= 3'h0;
    end else begin
      cfg_s1_q <= cfg_q[2:0];
      cfg_s2_q <= cfg_s1_q;
    end
  end

  assign tbl_en   = cfg_s2_q[link_startup_pkg::CFG_TABLE_EN];
  assign two_lane = cfg_s2_q[link_startup_pkg::CFG_TWO_LANE];

  // ====================
  // Start-up sequencer
  link_startup_pkg::seq_t seq_q;
  link_startup_pkg::seq_t seq_d;
  logic [link_startup_pkg::COUNT_W-1:0] cnt_q;
  logic [link_startup_pkg::COUNT_W-1:0] cnt_d;
  logic cnt_done;

  assign cnt_done = (cnt_q == '0);

  always_comb begin
    seq_d = seq_q;
    cnt_d = cnt_q - 1'b1;
    unique case (seq_q)
      link_startup_pkg::SEQ_OFF: begin
        seq_d = link_startup_pkg::SEQ_BIAS; // RULE7
        cnt_d = 10'(link_startup_pkg::BIAS_CYC - 1);
      end
      link_startup_pkg::SEQ_BIAS: if (cnt_done) begin
        seq_d = link_startup_pkg::SEQ_LOW1; // RULE8
        cnt_d = 10'(link_startup_pkg::LOW1_CYC - 1);
      end
      link_startup_pkg::SEQ_LOW1: if (cnt_done) begin
        seq_d = link_startup_pkg::SEQ_HIGH; // RULE9
        cnt_d = 10'(link_startup_pkg::HIGH_CYC - 1);
      end
      link_startup_pkg::SEQ_HIGH: if (cnt_done) begin
        seq_d = link_startup_pkg::SEQ_LOW2; // RULE10
        cnt_d = 10'(link_startup_pkg::LOW2_CYC - 1);
      end
      link_startup_pkg::SEQ_LOW2: if (cnt_done) begin
        seq_d = link_startup_pkg::SEQ_LOCK; // RULE11
        cnt_d = 10'(link_startup_pkg::LOCK_CYC - 1);
      end
      link_startup_pkg::SEQ_LOCK: if (cnt_done) begin
        seq_d = link_startup_pkg::SEQ_ACTIVE; // RULE17
      end
      link_startup_pkg::SEQ_ACTIVE: cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge pixel_clk or negedge prst_n) begin
    if (!prst_n) begin
      seq_q <= link_startup_pkg::SEQ_OFF; // RULE17
      cnt_q <= '0;
    end else begin
      seq_q <= seq_d;
      cnt_q <= cnt_d;
    end
  end

  // ====================
  // Line codes and phase
  logic       active;
  logic       md_low;
  logic [1:0] mc_d;
  logic [1:0] mc_q;
  logic [2:0] ph_d;
  logic [2:0] ph_q;
  logic [2:0][1:0] md_q;

  assign active = (seq_q == link_startup_pkg::SEQ_ACTIVE);
  assign md_low = (seq_q == link_startup_pkg::SEQ_LOW2) || (seq_q == link_startup_pkg::SEQ_LOCK);
  assign mc_d = active ? link_startup_pkg::LINE_ACTIVE :
                (seq_q == link_startup_pkg::SEQ_HIGH) ? link_startup_pkg::LINE_HIGH :
                ((seq_q == link_startup_pkg::SEQ_LOW1) || md_low) ? link_startup_pkg::LINE_LOW :
                link_startup_pkg::LINE_OFF; // RULE6
  assign ph_d = active ? link_startup_pkg::PHASE_ACTIVE :
                (seq_q == link_startup_pkg::SEQ_OFF) ? link_startup_pkg::PHASE_OFF :
                link_startup_pkg::PHASE_LINK_UP; // RULE4

  always_ff @(posedge pixel_clk or negedge prst_n) begin
    if (!prst_n) begin
      mc_q <= link_startup_pkg::LINE_OFF; // RULE5
      ph_q <= link_startup_pkg::PHASE_OFF;
    end else begin
      mc_q <= mc_d;
      ph_q <= ph_d;
    end
  end

  for (genvar l = 0; l < 3; l++) begin : g_md
    logic [1:0] md_d;
    assign md_d = (active && !(two_lane && l == 2)) ? link_startup_pkg::LINE_ACTIVE :
                  (md_low && !(two_lane && l == 2)) ? link_startup_pkg::LINE_LOW :
                  link_startup_pkg::LINE_OFF; // RULE18
    always_ff @(posedge pixel_clk or negedge prst_n) begin
      if (!prst_n) md_q[l] <= link_startup_pkg::LINE_OFF; // RULE5
      else         md_q[l] <= md_d;
    end
  end

  assign serial_link_clock = mc_q;
  assign serial_data_lane  = md_q;
  assign link_phase        = ph_q;
  assign pll_enable        = (seq_q == link_startup_pkg::SEQ_LOCK) || active; // RULE11

  // ====================
  // Pixel stream: sample, table, dither, pack
  logic [23:0]     rgb_s1_q;
  logic [23:0]     rgb_s2_q;
  logic [2:0]      sync_s1_q;
  logic [2:0]      sync_s2_q;
  logic [2:0][7:0] tbl_out;
  logic [1:0]      fseq_q;
  logic [23:0]     payload;
  logic [2:0][11:0] word_q;
  pixel_bus_if     pbus ();

  always_ff @(posedge pixel_clk or negedge prst_n) begin
    if (!prst_n) begin
      rgb_s1_q  <= 24'h000000;
      rgb_s2_q  <= 24'h000000;
      sync_s1_q <= 3'h0;
      sync_s2_q <= 3'h0;
    end else begin
      rgb_s1_q  <= rgb_in; // RULE1
      rgb_s2_q  <= rgb_s1_q;
      sync_s1_q <= {pixel_valid, line_sync, frame_sync};
      sync_s2_q <= sync_s1_q;
    end
  end

  color_table u_table (
    .wclk  (clk),
    .we    (twe),
    .wsel  (tsel_q),
    .waddr (tidx_q),
    .wdata (frame_data),
    .rclk  (pixel_clk),
    .raddr ({rgb_s1_q[23:16], rgb_s1_q[15:8], rgb_s1_q[7:0]}),
    .rdata (tbl_out)
  ); // RULE3

  assign pbus.rgb24       = tbl_en ? tbl_out : rgb_s2_q;
  assign pbus.frame_start = sync_s1_q[0] & ~sync_s2_q[0];
  assign pbus.bypass      = cfg_s2_q[link_startup_pkg::CFG_DITHER_OFF];

  pixel_dither u_dither (
    .clk   (pixel_clk),
    .rst_n (prst_n),
    .bus   (pbus)
  ); // RULE2

  assign payload = {~^{fseq_q, sync_s2_q, pbus.rgb18}, fseq_q, sync_s2_q, pbus.rgb18};

  always_ff @(posedge pixel_clk or negedge prst_n) begin
    if (!prst_n)     fseq_q <= 2'h0;
    else if (active) fseq_q <= fseq_q + 2'h1;
  end

  for (genvar l = 0; l < 3; l++) begin : g_pack
    logic [11:0] w_d;
    assign w_d = !active ? 12'h000 :
                 two_lane ? ((l == 2) ? 12'h000 : payload[12*(l%2) +: 12]) :
                 {payload[8*l +: 8], 4'h0}; // RULE15
    always_ff @(posedge pixel_clk or negedge prst_n) begin
      if (!prst_n) word_q[l] <= 12'h000;
      else         word_q[l] <= w_d; // RULE1
    end
  end

  assign lane_word = word_q;
  assign lane_bits = two_lane ? link_startup_pkg::BITS_2LANE : link_startup_pkg::BITS_3LANE; // RULE20

endmodule : pixel_serial_link_startup
